/* include/sar_pkg.sv */
// Shared constants and types for the converter serial readout
package sar_pkg;
  localparam int          RES_BITS      = 16;
  localparam int          CNT_W         = 3;
  localparam int          LOG_DEPTH     = 32;
  localparam logic [2:0]  SAMPLE_FALLS  = 3'h5;
  localparam logic [3:0]  TOP_IDX       = 4'hf;
  localparam logic [3:0]  BOTTOM_IDX    = 4'h0;
  localparam logic [3:0]  FIRST_REP_IDX = 4'h1;
  localparam logic [15:0] TRIAL_START   = 16'h8000;
  localparam logic [15:0] CODE_RESET    = 16'h0000;

  typedef enum logic [2:0] {
    SAR_IDLE,
    SAR_SAMPLE,
    SAR_NULL,
    SAR_CONV,
    SAR_REPEAT,
    SAR_TAIL,
    SAR_DONE
  } sar_state_t;
endpackage

/* rtl/sar_fifo.sv */
// Result log FIFO with valid/ready on both sides
`timescale 1ns/1ps
module sar_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 32
) (
  input  wire logic             sys_clk,
  input  wire logic             sys_rst,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr_r;
  logic [AW-1:0]    wr_ptr_nxt;
  logic [AW-1:0]    rd_ptr_r;
  logic [AW-1:0]    rd_ptr_nxt;
  logic [AW:0]      count_r;
  logic [AW:0]      count_nxt;
  logic             push;
  logic             pop;

  assign in_ready  = (count_r != (AW + 1)'(DEPTH));
  assign out_valid = (count_r != '0);
  assign out_data  = mem[rd_ptr_r];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb begin
    wr_ptr_nxt = push ? AW'(wr_ptr_r + 1'b1) : wr_ptr_r;
    rd_ptr_nxt = pop ? AW'(rd_ptr_r + 1'b1) : rd_ptr_r;
    count_nxt  = count_r;
    if (push && !pop) begin
      count_nxt = (AW + 1)'(count_r + 1'b1);
    end else if (pop && !push) begin
      count_nxt = (AW + 1)'(count_r - 1'b1);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r  <= '0;
    end else begin
      wr_ptr_r <= wr_ptr_nxt;
      rd_ptr_r <= rd_ptr_nxt;
      count_r  <= count_nxt;
    end
  end

  // Storage has no reset; only the pointers and count_r define what is valid
  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem[wr_ptr_r] <= in_data;
    end
  end
endmodule // sar_fifo

/* rtl/sar_adc_readout.sv */
// Conversion sequencing and serial readout of the successive-approximation converter
`timescale 1ns/1ps
module sar_adc_readout
  import sar_pkg::*;
(
  input  wire logic                sys_clk,
  input  wire logic                sys_rst,
  input  wire logic                select_n,
  input  wire logic                conversion_clock,
  input  wire logic                comparator_in,
  output logic [RES_BITS-1:0]      dac_code,
  output logic                     sample_active,
  output logic                     analog_active,
  output logic                     digital_active,
  output logic                     serial_data_out,
  output logic                     serial_data_oe,
  output logic                     result_valid,
  input  wire logic                result_ready,
  output logic [RES_BITS-1:0]      result_data,
  output logic                     result_log_ready
);
  sar_state_t          state_r;
  sar_state_t          state_nxt;
  logic [CNT_W-1:0]    cnt_r;
  logic [CNT_W-1:0]    cnt_nxt;
  logic [3:0]          bit_idx_r;
  logic [3:0]          bit_idx_nxt;
  logic [RES_BITS-1:0] trial_r;
  logic [RES_BITS-1:0] trial_nxt;
  logic [RES_BITS-1:0] result_r;
  logic [RES_BITS-1:0] result_nxt;
  logic                sdo_r;
  logic                sdo_nxt;
  logic                oe_r;
  logic                oe_nxt;
  logic                clk_q_r;
  logic                clk_fall;
  logic                log_push;
  logic                rep_bit;

  // Conversion clock is synchronous to sys_clk; edges come from one stored sample
  assign clk_fall        = clk_q_r && !conversion_clock;
  assign dac_code        = trial_r;
  assign serial_data_out = sdo_r;
  assign serial_data_oe  = oe_r;
  assign rep_bit         = result_r[bit_idx_r];
  assign sample_active   = (state_r == SAR_SAMPLE);
  assign analog_active   = (state_r == SAR_SAMPLE) || (state_r == SAR_NULL) || (state_r == SAR_CONV);
  assign digital_active  = (state_r != SAR_IDLE);

  // Offset-binary decision: keep the comparator verdict, set the next trial bit
  function automatic logic [RES_BITS-1:0] sar_decide(input logic [RES_BITS-1:0] trial,
                                                     input logic [3:0]          idx,
                                                     input logic                cmp);
    logic [RES_BITS-1:0] t;
    t      = trial;
    t[idx] = cmp;
    if (idx != BOTTOM_IDX) begin
      t[idx - 1'b1] = 1'b1;
    end
    return t;
  endfunction

  always_comb begin
    state_nxt   = state_r;
    cnt_nxt     = cnt_r;
    bit_idx_nxt = bit_idx_r;
    trial_nxt   = trial_r;
    result_nxt  = result_r;
    sdo_nxt     = sdo_r;
    oe_nxt      = oe_r;
    log_push    = 1'b0;
    if (select_n) begin
      state_nxt   = SAR_IDLE;
      cnt_nxt     = '0;
      bit_idx_nxt = TOP_IDX;
      trial_nxt   = CODE_RESET;
      sdo_nxt     = 1'b0;
      oe_nxt      = 1'b0;
    end else begin
      unique case (state_r)
        SAR_IDLE: begin
          state_nxt = SAR_SAMPLE;
          cnt_nxt   = '0;
        end
        SAR_SAMPLE: begin
          if (clk_fall) begin
            cnt_nxt = CNT_W'(cnt_r + 1'b1);
            if (cnt_r == SAMPLE_FALLS - 1'b1) begin
              state_nxt   = SAR_NULL;
              oe_nxt      = 1'b1;
              sdo_nxt     = 1'b0;
              trial_nxt   = TRIAL_START;
              bit_idx_nxt = TOP_IDX;
            end
          end
        end
        SAR_NULL, SAR_CONV: begin
          if (clk_fall) begin
            // Bit goes out in the same edge it is decided: no latency
            trial_nxt = sar_decide(trial_r, bit_idx_r, comparator_in);
            sdo_nxt   = (bit_idx_r == TOP_IDX) ? !comparator_in : comparator_in;
            if (bit_idx_r == BOTTOM_IDX) begin
              result_nxt  = {!trial_nxt[RES_BITS-1], trial_nxt[RES_BITS-2:0]};
              log_push    = 1'b1;
              state_nxt   = SAR_REPEAT;
              bit_idx_nxt = FIRST_REP_IDX;
            end else begin
              state_nxt   = SAR_CONV;
              bit_idx_nxt = bit_idx_r - 1'b1;
            end
          end
        end
        SAR_REPEAT: begin
          if (clk_fall) begin
            sdo_nxt = rep_bit;
            if (bit_idx_r == TOP_IDX) begin
              state_nxt = SAR_TAIL;
            end else begin
              bit_idx_nxt = bit_idx_r + 1'b1;
            end
          end
        end
        SAR_TAIL: begin
          if (clk_fall) begin
            oe_nxt    = 1'b0;
            sdo_nxt   = 1'b0;
            state_nxt = SAR_DONE;
          end
        end
        SAR_DONE: begin
          state_nxt = SAR_DONE;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      state_r   <= SAR_IDLE;
      cnt_r     <= '0;
      bit_idx_r <= TOP_IDX;
      trial_r   <= CODE_RESET;
      result_r  <= CODE_RESET;
      sdo_r     <= 1'b0;
      oe_r      <= 1'b0;
      clk_q_r   <= 1'b0;
    end else begin
      state_r   <= state_nxt;
      cnt_r     <= cnt_nxt;
      bit_idx_r <= bit_idx_nxt;
      trial_r   <= trial_nxt;
      result_r  <= result_nxt;
      sdo_r     <= sdo_nxt;
      oe_r      <= oe_nxt;
      clk_q_r   <= conversion_clock;
    end
  end

  // A full log drops the new result; result_log_ready lets the user see that coming
  sar_fifo #(
    .WIDTH (RES_BITS),
    .DEPTH (LOG_DEPTH)
  ) u_log (
    .sys_clk   (sys_clk),
    .sys_rst   (sys_rst),
    .in_valid  (log_push),
    .in_ready  (result_log_ready),
    .in_data   (result_nxt),
    .out_valid (result_valid),
    .out_ready (result_ready),
    .out_data  (result_data)
  );

  chk_shift_fall: assert property (@(posedge sys_clk) disable iff (sys_rst)
    ($changed(sdo_r) && !$past(select_n)) |-> $past(clk_fall))
    else $error("serial bit changed without a clock fall");
  chk_start_seq: assert property (@(posedge sys_clk) disable iff (sys_rst)
    ($past(select_n) && !select_n) |=> (state_r == SAR_SAMPLE) && (cnt_r == '0))
    else $error("select fall did not start sampling");
  chk_sample_quiet: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (state_r == SAR_SAMPLE) |-> !oe_r)
    else $error("output enabled during sample phase");
  chk_null_bit: assert property (@(posedge sys_clk) disable iff (sys_rst)
    $rose(oe_r) |-> !sdo_r && (state_r == SAR_NULL) && (cnt_r == SAMPLE_FALLS))
    else $error("null bit not low on fifth fall");
  chk_decide_bit: assert property (@(posedge sys_clk) disable iff (sys_rst || select_n)
    (state_r == SAR_CONV && clk_fall && !select_n) |=> (sdo_r == $past(comparator_in)))
    else $error("result bit not the current decision");
  chk_sign_bit: assert property (@(posedge sys_clk) disable iff (sys_rst || select_n)
    (state_r == SAR_NULL && clk_fall && !select_n) |=> (sdo_r == !$past(comparator_in)))
    else $error("sign bit not two's complement");
  chk_repeat_lsb: assert property (@(posedge sys_clk) disable iff (sys_rst || select_n)
    (state_r == SAR_REPEAT && clk_fall && !select_n) |=> (sdo_r == $past(rep_bit)))
    else $error("repeated bit wrong");
  chk_tail_tri: assert property (@(posedge sys_clk) disable iff (sys_rst || select_n)
    (state_r == SAR_TAIL && clk_fall && !select_n) |=> !oe_r && (state_r == SAR_DONE))
    else $error("output not tri-stated after repeat");
  chk_done_hold: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (state_r == SAR_DONE && !select_n) |=> (state_r == SAR_DONE) && !oe_r)
    else $error("clocking disturbed finished conversion");
  chk_abort_clear: assert property (@(posedge sys_clk) disable iff (sys_rst)
    select_n |=> (state_r == SAR_IDLE) && !oe_r && (cnt_r == '0))
    else $error("select high did not abort and clear");
  chk_power_split: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (state_r == SAR_DONE) |-> !analog_active && digital_active)
    else $error("power state wrong after completion");

  cov_full_conv: cover property (@(posedge sys_clk) disable iff (sys_rst)
    (state_r == SAR_TAIL) ##1 (state_r == SAR_DONE));
  cov_short_cycle: cover property (@(posedge sys_clk) disable iff (sys_rst)
    (state_r == SAR_CONV) ##1 (state_r == SAR_IDLE));
  cov_log_full: cover property (@(posedge sys_clk) disable iff (sys_rst)
    !result_log_ready);
endmodule // sar_adc_readout

/* dv/sar_cmp_model.sv */
// Comparator model standing in for the analog input and the capacitor array
`timescale 1ns/1ps
module sar_cmp_model
  import sar_pkg::*;
(
  input  wire logic [RES_BITS-1:0] vin_code,
  input  wire logic [RES_BITS-1:0] dac_code,
  output logic                     comparator_in
);
  // Input is held as two's complement; the array weighs in offset binary
  assign comparator_in = ((vin_code ^ TRIAL_START) >= dac_code);
endmodule // sar_cmp_model

/* dv/test_sar_adc_readout.sv */
// Self-checking bench for the converter serial readout
`timescale 1ns/1ps
module test_sar_adc_readout
  import sar_pkg::*;
;
  logic                sys_clk;
  logic                sys_rst;
  logic                select_n;
  logic                conversion_clock;
  logic                comparator_in;
  logic                result_ready;
  logic [RES_BITS-1:0] vin_code;
  logic [RES_BITS-1:0] dac_code;
  logic [RES_BITS-1:0] result_data;
  logic                sample_active;
  logic                analog_active;
  logic                digital_active;
  logic                serial_data_out;
  logic                serial_data_oe;
  logic                result_valid;
  logic                result_log_ready;
  int                  bad_count;
  int                  checked;
  int                  cycles;

  sar_adc_readout sar_adc_readout_i (
    .sys_clk          (sys_clk),
    .sys_rst          (sys_rst),
    .select_n         (select_n),
    .conversion_clock (conversion_clock),
    .comparator_in    (comparator_in),
    .dac_code         (dac_code),
    .sample_active    (sample_active),
    .analog_active    (analog_active),
    .digital_active   (digital_active),
    .serial_data_out  (serial_data_out),
    .serial_data_oe   (serial_data_oe),
    .result_valid     (result_valid),
    .result_ready     (result_ready),
    .result_data      (result_data),
    .result_log_ready (result_log_ready)
  );

  sar_cmp_model sar_cmp_model_i (
    .vin_code      (vin_code),
    .dac_code      (dac_code),
    .comparator_in (comparator_in)
  );

  always #50 sys_clk = ~sys_clk;

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic results();
    $display("comparisons %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // One conversion of n clock periods, then select released
  task automatic conv(input logic [15:0] v, input int n);
    logic [1:0] exp;
    vin_code <= v;
    select_n <= 1'b0;
    for (int p = 1; p <= n; p++) begin
      conversion_clock <= 1'b1;
      tick(2);
      // Host takes each bit at the end of the high phase, well clear of the launch
      if (p < 6 || p > 37)
        exp = 2'b00;
      else if (p == 6)
        exp = 2'b10;
      else if (p <= 22)
        exp = {1'b1, v[22-p]};
      else
        exp = {1'b1, v[p-22]};
      chk({14'h0, serial_data_oe, serial_data_out}, {14'h0, exp});
      chk({14'h0, sample_active, analog_active}, {14'h0, 1'(p <= 5), 1'(p <= 21)});
      conversion_clock <= 1'b0;
      tick(2);
    end
    if (n >= 22) begin
      chk({15'h0, analog_active}, 16'h0);
      chk({15'h0, digital_active}, 16'h1);
    end
    select_n <= 1'b1;
    tick(3);
    chk({15'h0, serial_data_oe}, 16'h0);
    chk({15'h0, digital_active}, 16'h0);
    chk(dac_code, CODE_RESET);
  endtask

  task automatic pop(input logic [15:0] exp);
    tick(1);
    chk({15'h0, result_valid}, 16'h1);
    chk(result_data, exp);
    result_ready <= 1'b1;
    tick(1);
    result_ready <= 1'b0;
  endtask

  task automatic test_codes();
    logic [15:0] codes [5] = '{16'h7fff, 16'h0000, 16'hffff, 16'h8000, 16'ha5c3};
    for (int i = 0; i < 5; i++) begin
      conv(codes[i], 45);
      pop(codes[i]);
    end
    $display("test codes done");
  endtask

  // Short cycle in mid-result, then a clean restart from the sample phase
  task automatic test_abort();
    conv(16'h1234, 10);
    chk({15'h0, result_valid}, 16'h0);
    conv(16'h1234, 45);
    pop(16'h1234);
    $display("test abort done");
  endtask

  // Log fills with the reader stalled, drops one, then drains in order
  task automatic test_fifo();
    for (int i = 0; i <= LOG_DEPTH; i++)
      conv(16'h0100 + 16'(i), 22);
    chk({15'h0, result_log_ready}, 16'h0);
    for (int i = 0; i < LOG_DEPTH; i++)
      pop(16'h0100 + 16'(i));
    tick(1);
    chk({15'h0, result_valid}, 16'h0);
    $display("test fifo done");
  endtask

  // Tests need some 4200 cycles; the ceiling leaves ample margin
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      $display("[ERR] %0t run did not finish", $time);
      results();
    end
  end

  initial begin
    sys_clk = 1'b0;
    sys_rst = 1'b1;
    select_n = 1'b1;
    conversion_clock = 1'b0;
    result_ready = 1'b0;
    vin_code = 16'h0000;
    bad_count = 0;
    checked = 0;
    cycles = 0;
    tick(10);
    sys_rst <= 1'b0;
    tick(2);
    test_codes();
    test_abort();
    test_fifo();
    results();
  end
endmodule // test_sar_adc_readout
